// file: design/gpb_regs.svh
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH

// Register byte offsets.
`define GPB_OFS_SLEEP_A      8'h66
`define GPB_OFS_SLEEP_B      8'h67
`define GPB_OFS_PWM          8'h68

// Field positions.
`define GPB_BIT_SET          0
`define GPB_BIT_LEVEL        1
`define GPB_BIT_DIR          2
`define GPB_BIT_PDEN         3
`define GPB_BIT_DEB          4
`define GPB_BIT_SRC          5
`define GPB_BIT_SLEEP        7

// Reset values of the register fields.
`define GPB_RST_SET          1'b0
`define GPB_RST_DIR          1'b0
`define GPB_RST_PDEN         1'b1
`define GPB_RST_DEB          1'b0
`define GPB_RST_SRC          1'b0
`define GPB_RST_SLEEP        1'b0
`define GPB_RST_LEVEL        1'b1

// Debounce timing at a 4 ns clock; times in nanoseconds.
`define GPB_CLK_PERIOD_NS    4
`define GPB_FAST_TICK_NS     30500
`define GPB_FAST_DEB_NS      91500
`define GPB_SLOW_TICK_NS     50000000
`define GPB_SLOW_DEB_NS      150000000
`define GPB_FAST_TICK_CYC    (`GPB_FAST_TICK_NS / `GPB_CLK_PERIOD_NS)
`define GPB_SLOW_TICK_CYC    (`GPB_SLOW_TICK_NS / `GPB_CLK_PERIOD_NS)
`define GPB_FAST_SAMPLES     (`GPB_FAST_DEB_NS / `GPB_FAST_TICK_NS)
`define GPB_SLOW_SAMPLES     (`GPB_SLOW_DEB_NS / `GPB_SLOW_TICK_NS)

`endif

// file: design/gpb_pkg.sv
package gpb_pkg;
  typedef logic [7:0] gpb_byte_t;
  typedef logic [23:0] gpb_cnt_t;
  typedef logic [1:0] gpb_smp_t;
  typedef enum logic [1:0] {
    GPB_PWR_ACTIVE = 2'b01,
    GPB_PWR_SLEEP  = 2'b10
  } gpb_pwr_t;
endpackage

// file: design/gpb_gpio_bank.sv
`timescale 1ns/10ps
`include "gpb_regs.svh"

// Contract
// - On the two sleep pins a set sleep-force bit 7 drives the pad low as an output in sleep.
// - Debounce select 0 filters the pad over 91.5 us with 30.5 us samples.
// - Debounce select 1 filters the pad over 150 ms with 50 ms samples.
// - The pulldown enable bit switches the pad pulldown and resets to 1.
// - A power-off reset clears pulldown enable on a sleep pin in the power-up sequence.
// - The direction bit selects input at 0 and output at 1 and resets to 0.
// - A power-off reset sets direction to output on a sleep pin in the power-up sequence.
// - The direction reset value of the two sleep pins comes from the boot configuration.
// - Bit 1 reads the debounced pad level, resets to 1 and ignores writes.
// - An output pad is driven with output-value bit 0, which resets to 0.
// - A power-off reset returns output value to 0 on a sleep pin in the power-up sequence.
// - On the PWM pin bit 5 routes the output value at 0 or the PWM signal at 1.
module gpb_gpio_bank
  import gpb_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // System control.
  input  wire logic [1:0] boot_dir,
  input  wire logic [1:0] in_pwrup_seq,
  input  wire logic       power_off_reset,
  input  wire logic       sleep_state,
  input  wire logic       pwm_in,
  // Pads, index 0 and 1 sleep pins, index 2 the PWM pin.
  input  wire logic [2:0] pad_in,
  output logic      [2:0] pad_out,
  output logic      [2:0] pad_oe,
  output logic      [2:0] pad_pulldown
);

  logic [2:0] set_ff;
  logic [2:0] dir_ff;
  logic [2:0] pden_ff;
  logic [2:0] deb_ff;
  logic [2:0] level_ff;
  logic [2:0] nxt_set;
  logic [2:0] nxt_dir;
  logic [2:0] nxt_pden;
  logic [2:0] nxt_deb;
  logic [2:0] nxt_level;
  logic [1:0] sleep_ff;
  logic [1:0] nxt_sleep;
  logic       src_ff;
  logic       nxt_src;
  logic       boot_done_ff;

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  gpb_cnt_t   fast_cnt_ff;
  gpb_cnt_t   slow_cnt_ff;
  gpb_cnt_t   nxt_fast_cnt;
  gpb_cnt_t   nxt_slow_cnt;
  logic       fast_tick_ff;
  logic       slow_tick_ff;
  logic       nxt_fast_tick;
  logic       nxt_slow_tick;
  gpb_smp_t   smp_cnt_ff [3];
  gpb_smp_t   nxt_smp_cnt [3];

  logic [7:0] nxt_rdata;
  logic [2:0] nxt_out;
  logic [2:0] nxt_oe;
  gpb_pwr_t   pwr;

  localparam gpb_cnt_t FAST_LAST = gpb_cnt_t'(`GPB_FAST_TICK_CYC - 1);
  localparam gpb_cnt_t SLOW_LAST = gpb_cnt_t'(`GPB_SLOW_TICK_CYC - 1);
  localparam gpb_smp_t FAST_N    = gpb_smp_t'(`GPB_FAST_SAMPLES);
  localparam gpb_smp_t SLOW_N    = gpb_smp_t'(`GPB_SLOW_SAMPLES);

  function automatic gpb_byte_t read_pin(input logic sl,
                                         input logic src,
                                         input logic deb,
                                         input logic pd,
                                         input logic dir,
                                         input logic lv,
                                         input logic st);
    gpb_byte_t r;
    r = 8'h00;
    r[`GPB_BIT_SLEEP] = sl;
    r[`GPB_BIT_SRC]   = src;
    r[`GPB_BIT_DEB]   = deb;
    r[`GPB_BIT_PDEN]  = pd;
    r[`GPB_BIT_DIR]   = dir;
    r[`GPB_BIT_LEVEL] = lv;
    r[`GPB_BIT_SET]   = st;
    return r;
  endfunction

  // Register decode, shared by the write and read paths.
  function automatic logic addr_hit(input gpb_byte_t addr, input gpb_byte_t ofs);
    return addr == ofs;
  endfunction

  // Last sample index of a debounce window for the selected rate.
  function automatic gpb_smp_t smp_last(input logic slow);
    gpb_smp_t n;
    n = slow ? SLOW_N : FAST_N;
    return n - 2'h1;
  endfunction

  assign pwr = sleep_state ? GPB_PWR_SLEEP : GPB_PWR_ACTIVE;

  // Pad inputs come from outside, so two flops precede any use.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Sample tick dividers.
  // Each tick lasts one cycle; a pad sample is taken only on it.
  always_comb begin
    nxt_fast_tick = (fast_cnt_ff == FAST_LAST);
    if (nxt_fast_tick) begin
      nxt_fast_cnt = 24'h000000;
    end else begin
      nxt_fast_cnt = fast_cnt_ff + 24'h000001;
    end
    nxt_slow_tick = (slow_cnt_ff == SLOW_LAST);
    if (nxt_slow_tick) begin
      nxt_slow_cnt = 24'h000000;
    end else begin
      nxt_slow_cnt = slow_cnt_ff + 24'h000001;
    end
  end

  // Both dividers run free, so a change of rate takes effect at the next tick.

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fast_cnt_ff  <= 24'h000000;
      slow_cnt_ff  <= 24'h000000;
      fast_tick_ff <= 1'b0;
      slow_tick_ff <= 1'b0;
    end else begin
      fast_cnt_ff  <= nxt_fast_cnt;
      slow_cnt_ff  <= nxt_slow_cnt;
      fast_tick_ff <= nxt_fast_tick;
      slow_tick_ff <= nxt_slow_tick;
    end
  end

  // The level changes only after three equal differing samples in a row.
  always_comb begin
    nxt_level = level_ff;
    for (int i = 0; i < 3; i++) begin
      nxt_smp_cnt[i] = smp_cnt_ff[i];
      if (deb_ff[i] ? slow_tick_ff : fast_tick_ff) begin
        if (sync2_ff[i] == level_ff[i]) begin
          nxt_smp_cnt[i] = 2'h0;
        end else if (smp_cnt_ff[i] == smp_last(deb_ff[i])) begin
          nxt_smp_cnt[i] = 2'h0;
          nxt_level[i]   = sync2_ff[i];
        end else begin
          nxt_smp_cnt[i] = smp_cnt_ff[i] + 2'h1;
        end
      end
    end
  end

  // Level starts high so the status bit reads 1 straight after reset.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= {3{`GPB_RST_LEVEL}};
      for (int i = 0; i < 3; i++) begin
        smp_cnt_ff[i] <= 2'h0;
      end
    end else begin
      level_ff <= nxt_level;
      smp_cnt_ff <= nxt_smp_cnt;
    end
  end

  // Configuration registers.
  always_comb begin
    nxt_set   = set_ff;
    nxt_dir   = dir_ff;
    nxt_pden  = pden_ff;
    nxt_deb   = deb_ff;
    nxt_sleep = sleep_ff;
    nxt_src   = src_ff;
    for (int i = 0; i < 3; i++) begin
      // A write to an unmapped address matches no offset and is dropped.
      if (reg_wr && addr_hit(reg_addr, `GPB_OFS_SLEEP_A + 8'(i))) begin
        nxt_set[i]  = reg_wdata[`GPB_BIT_SET];
        nxt_dir[i]  = reg_wdata[`GPB_BIT_DIR];
        nxt_pden[i] = reg_wdata[`GPB_BIT_PDEN];
        nxt_deb[i]  = reg_wdata[`GPB_BIT_DEB];
      end
    end
    if (reg_wr && addr_hit(reg_addr, `GPB_OFS_SLEEP_A)) begin
      nxt_sleep[0] = reg_wdata[`GPB_BIT_SLEEP];
    end else if (reg_wr && addr_hit(reg_addr, `GPB_OFS_SLEEP_B)) begin
      nxt_sleep[1] = reg_wdata[`GPB_BIT_SLEEP];
    end else if (reg_wr && addr_hit(reg_addr, `GPB_OFS_PWM)) begin
      nxt_src = reg_wdata[`GPB_BIT_SRC];
    end
    // Strap capture of the boot direction once after reset release.
    if (!boot_done_ff) begin
      nxt_dir[1:0] = boot_dir;
    end
    // Power-off reset overrides a same-cycle write.
    for (int i = 0; i < 2; i++) begin
      if (power_off_reset && in_pwrup_seq[i]) begin
        nxt_pden[i] = 1'b0;
        nxt_dir[i]  = 1'b1;
        nxt_set[i]  = `GPB_RST_SET;
      end
    end
  end

  // The boot flag lets the direction straps load only once per reset.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      set_ff       <= {3{`GPB_RST_SET}};
      dir_ff       <= {3{`GPB_RST_DIR}};
      pden_ff      <= {3{`GPB_RST_PDEN}};
      deb_ff       <= {3{`GPB_RST_DEB}};
      sleep_ff     <= {2{`GPB_RST_SLEEP}};
      src_ff       <= `GPB_RST_SRC;
      boot_done_ff <= 1'b0;
    end else begin
      set_ff       <= nxt_set;
      dir_ff       <= nxt_dir;
      pden_ff      <= nxt_pden;
      deb_ff       <= nxt_deb;
      sleep_ff     <= nxt_sleep;
      src_ff       <= nxt_src;
      boot_done_ff <= 1'b1;
    end
  end

  // Pad drive and read data.
  // Sleep forcing outranks the direction bit on the two sleep pins; the PWM pin is never forced.
  always_comb begin
    nxt_oe  = dir_ff;
    nxt_out = set_ff & dir_ff;
    if (dir_ff[2] && src_ff) begin
      nxt_out[2] = pwm_in;
    end
    for (int i = 0; i < 2; i++) begin
      if (pwr == GPB_PWR_SLEEP && sleep_ff[i]) begin
        nxt_oe[i]  = 1'b1;
        nxt_out[i] = 1'b0;
      end
    end
    nxt_rdata = 8'h00;
    // Reserved bits and unmapped addresses read as zero.
    if (reg_rd && addr_hit(reg_addr, `GPB_OFS_SLEEP_A)) begin
      nxt_rdata = read_pin(sleep_ff[0],
                           1'b0,
                           deb_ff[0],
                           pden_ff[0],
                           dir_ff[0],
                           level_ff[0],
                           set_ff[0]);
    end else if (reg_rd && addr_hit(reg_addr, `GPB_OFS_SLEEP_B)) begin
      nxt_rdata = read_pin(sleep_ff[1],
                           1'b0,
                           deb_ff[1],
                           pden_ff[1],
                           dir_ff[1],
                           level_ff[1],
                           set_ff[1]);
    end else if (reg_rd && addr_hit(reg_addr, `GPB_OFS_PWM)) begin
      nxt_rdata = read_pin(1'b0,
                           src_ff,
                           deb_ff[2],
                           pden_ff[2],
                           dir_ff[2],
                           level_ff[2],
                           set_ff[2]);
    end
  end

  // Every pad signal leaves a flop, so the pads see no combinational glitch.

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata    <= 8'h00;
      pad_out      <= 3'h0;
      pad_oe       <= 3'h0;
      pad_pulldown <= 3'h7;
    end else begin
      reg_rdata    <= nxt_rdata;
      pad_out      <= nxt_out;
      pad_oe       <= nxt_oe;
      pad_pulldown <= pden_ff;
    end
  end

endmodule // gpb_gpio_bank

// file: tb/gpb_gpio_bank_sva.sv
`timescale 1ns/10ps
module gpb_gpio_chk (
  // Clock, reset and register port.
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // System control and pads.
  input wire logic [1:0] boot_dir,
  input wire logic [1:0] in_pwrup_seq,
  input wire logic       power_off_reset,
  input wire logic       sleep_state,
  input wire logic       pwm_in,
  input wire logic [2:0] pad_in,
  input wire logic [2:0] pad_out,
  input wire logic [2:0] pad_oe,
  input wire logic [2:0] pad_pulldown
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence rd_a;
    reg_rd && reg_addr == 8'h66 && !power_off_reset;
  endsequence
  sequence seen_a(logic f7, logic f2, logic slp);
    rd_a ##1 reg_rdata[7] == f7 && reg_rdata[2] == f2 && sleep_state == slp;
  endsequence
  AST_POR_A: assert property (
    power_off_reset && in_pwrup_seq[0] |-> ##2 pad_oe[0] && !pad_pulldown[0] && !pad_out[0])
    else $error("power-off reset left pin a unchanged");
  AST_NO_DRIVE: assert property (!pad_oe[2] |-> !pad_out[2])
    else $error("pad value without output enable");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (
    $past(reg_rd) && ($past(reg_addr) < 8'h66 || $past(reg_addr) > 8'h68) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RSV_ZERO: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h68 |-> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits not zero");
  AST_SLEEP_FORCE: assert property (seen_a(1'b1, 1'b1, 1'b1) |=> pad_oe[0] && !pad_out[0])
    else $error("sleep force missing");
  AST_ACTIVE_KEEP: assert property (seen_a(1'b1, 1'b0, 1'b0) |=> !pad_oe[0])
    else $error("sleep force outside sleep");
  AST_PD_FOLLOW: assert property (rd_a ##1 1'b1 |=> pad_pulldown[0] == $past(reg_rdata[3]))
    else $error("pulldown differs from register");
endmodule // gpb_gpio_chk

bind gpb_gpio_bank gpb_gpio_chk chk_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .boot_dir(boot_dir), .in_pwrup_seq(in_pwrup_seq), .power_off_reset(power_off_reset),
  .sleep_state(sleep_state), .pwm_in(pwm_in), .pad_in(pad_in), .pad_out(pad_out),
  .pad_oe(pad_oe), .pad_pulldown(pad_pulldown));

// file: tb/gpb_pad_model.sv
`timescale 1ns/10ps
module gpb_pad_model (
  // Clock and design pad signals.
  input  wire logic       core_clk,
  input  wire logic [2:0] pad_out,
  input  wire logic [2:0] pad_oe,
  input  wire logic [2:0] pad_pulldown,
  // External drivers set by the bench.
  input  wire logic [2:0] ext_en,
  input  wire logic [2:0] ext_val,
  output logic      [2:0] pad_in
);
  logic flt_ff = 1'b0;
  // A pad that nobody drives and nothing pulls wanders, so it toggles.
  always_ff @(posedge core_clk) flt_ff <= ~flt_ff;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : !pad_pulldown[i] & flt_ff;
    end
  end
endmodule // gpb_pad_model

// file: tb/test_gpb_gpio_bank.sv
`timescale 1ns/10ps
`include "gpb_regs.svh"
module test_gpb_gpio_bank;
  logic       core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] boot_dir = 2'b10, in_pwrup_seq = 2'b00;
  logic       power_off_reset = 1'b0, sleep_state = 1'b0, pwm_in = 1'b0;
  logic [2:0] pad_in, pad_out, pad_oe, pad_pulldown, ext_en = 3'b110, ext_val = 3'b110;
  int         n_fail = 0, samples_checked = 0, cyc = 0;
  gpb_gpio_bank dut_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_dir(boot_dir), .in_pwrup_seq(in_pwrup_seq), .power_off_reset(power_off_reset),
    .sleep_state(sleep_state), .pwm_in(pwm_in), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pulldown(pad_pulldown));
  gpb_pad_model pad_u (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pulldown(pad_pulldown), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  initial forever #2 core_clk = ~core_clk;
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      stop_test;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk); reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk); reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({5'h00, pad_oe}, 8'h02);
    chk({5'h00, pad_pulldown}, 8'h07);
    chk({5'h00, pad_out}, 8'h00);
    rd(8'h66, 8'h0a);
    rd(8'h67, 8'h0e);
    rd(8'h68, 8'h0a);
    $display("test reset done");
    wr(8'h66, 8'hff); rd(8'h66, 8'h9f);
    wr(8'h68, 8'hff); rd(8'h68, 8'h3f);
    wr(8'h69, 8'hff); rd(8'h69, 8'h00);
    chk({7'h00, pad_out[2]}, 8'h00);
    @(posedge core_clk); pwm_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, pad_out[2]}, 8'h01);
    wr(8'h68, 8'h04); repeat (2) @(posedge core_clk);
    #1 chk({7'h00, pad_out[2]}, 8'h00);
    $display("test registers and source done");
    @(posedge core_clk); sleep_state <= 1'b1;
    rd(8'h66, 8'h9f);
    chk({5'h00, pad_oe}, 8'h07);
    chk({5'h00, pad_out}, 8'h00);
    @(posedge core_clk); sleep_state <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({5'h00, pad_out}, 8'h01);
    $display("test sleep done");
    @(posedge core_clk); in_pwrup_seq <= 2'b01;
    wr(8'h67, 8'h00); wr(8'h66, 8'h81); rd(8'h66, 8'h83);
    @(posedge core_clk); power_off_reset <= 1'b1;
    @(posedge core_clk); power_off_reset <= 1'b0;
    rd(8'h66, 8'h86);
    rd(8'h67, 8'h02);
    $display("test power-off reset done");
    @(posedge core_clk); ext_val <= 3'b000;
    wr(8'h68, 8'h00); wr(8'h67, 8'h10);
    repeat (`GPB_FAST_TICK_CYC + `GPB_FAST_TICK_CYC / 2) @(posedge core_clk);
    rd(8'h68, 8'h02);
    repeat (2 * `GPB_FAST_TICK_CYC) @(posedge core_clk);
    rd(8'h68, 8'h00);
    rd(8'h67, 8'h12);
    $display("test debounce done");
    stop_test;
  end
endmodule // test_gpb_gpio_bank
